// *** logic/dma_chan_flags.sv ***
// Purpose: Channel enable register and full-length / mid-point event flags
// Assumes: Engine strobes a channel each time it moves a byte on it
// Notes:   Read data is registered and appears one clock after the read
`timescale 1ns/1ps
module dma_chan_flags
	import dma_unit_pkg::*;
#(
	parameter int OFS_W = OFS_W_DEF
) (
	// Clock and reset
	input  wire logic                         i_mclk,
	input  wire logic                         i_rst_b,
	// Register bus
	input  wire sfr_req_s                     i_sfr,
	output logic      [SFR_W-1:0]             o_sfr_rdata,
	// Engine side
	input  wire logic [CHANNELS-1:0]          i_byte_moved,
	input  wire logic [CHANNELS-1:0][OFS_W-1:0] i_offset,
	input  wire logic [CHANNELS-1:0][OFS_W-1:0] i_size,
	input  wire chan_ie_s                     i_ie,
	// Channel controls and requests
	output logic      [CHANNELS-1:0]          o_chan_enable,
	output logic      [CHANNELS-1:0]          o_chan_go,
	output logic      [CHANNELS-1:0]          o_full_irq,
	output logic      [CHANNELS-1:0]          o_half_irq,
	output logic                              o_irq
);

	// Offset counter must be wide enough and narrow enough to serve
	if (OFS_W < 2 || OFS_W > 16) begin : g_bad_width
		$error("OFS_W must lie in 2..16");
	end

	flag_state_s                  st_r;
	flag_state_s                  st_nxt;
	logic [CHANNELS-1:0]          full_hit;
	logic [CHANNELS-1:0]          half_hit;
	logic                         wr_en;
	logic                         wr_full;
	logic                         wr_half;

	// Write decode
	assign wr_en   = i_sfr.wr && (i_sfr.addr == ADDR_ENABLE);
	assign wr_full = i_sfr.wr && (i_sfr.addr == ADDR_FULL);
	assign wr_half = i_sfr.wr && (i_sfr.addr == ADDR_HALF);

	// Per-channel offset comparators
	for (genvar c = 0; c < CHANNELS; c++) begin : g_cmp
		logic [OFS_W-1:0] last_ofs;
		logic [OFS_W-1:0] mid_ofs;
		assign last_ofs = OFS_W'(i_size[c] - 1'b1);
		assign mid_ofs  = OFS_W'(i_size[c] >> 1) + OFS_W'(i_size[c][0]);
		assign full_hit[c] = i_byte_moved[c] && (i_offset[c] == last_ofs);
		assign half_hit[c] = i_byte_moved[c] && (i_offset[c] == mid_ofs);
	end

	// Next-state: register writes, sticky flags with set over clear
	always_comb begin
		st_nxt = st_r;
		if (wr_en) begin
			st_nxt.enable = i_sfr.wdata[6:0];
		end
		if (wr_full) begin
			st_nxt.full = i_sfr.wdata[6:0];
		end
		if (wr_half) begin
			st_nxt.half = i_sfr.wdata[6:0];
		end
		st_nxt.full = st_nxt.full | full_hit;
		st_nxt.half = st_nxt.half | half_hit;
		// Read mux, top bit always zero, unmapped reads zero
		st_nxt.rdata = st_r.rdata;
		if (i_sfr.rd) begin
			case (i_sfr.addr)
				ADDR_ENABLE: st_nxt.rdata = {1'b0, st_r.enable};
				ADDR_FULL:   st_nxt.rdata = {1'b0, st_r.full};
				ADDR_HALF:   st_nxt.rdata = {1'b0, st_r.half};
				default:     st_nxt.rdata = RST_RDATA;
			endcase
		end
	end

	// State register
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '{enable: RST_ENABLE, full: RST_FLAGS,
				half: RST_FLAGS, rdata: RST_RDATA};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs: requests gated by the per-channel interrupt enables
	assign o_sfr_rdata   = st_r.rdata;
	assign o_chan_enable = st_r.enable;
	assign o_full_irq    = st_r.full & i_ie.full_ie;
	assign o_half_irq    = st_r.half & i_ie.half_ie;
	assign o_irq         = |{o_full_irq, o_half_irq};
	// A channel runs only when enabled and free of pending flags
	assign o_chan_go     = st_r.enable & ~st_r.full & ~st_r.half;

	// Checks on the register interface and the combined request
	sequence s_write_enable;
		i_sfr.wr && i_sfr.addr == ADDR_ENABLE;
	endsequence

	sequence s_read_full;
		i_sfr.rd && i_sfr.addr == ADDR_FULL;
	endsequence

	sequence s_read_enable;
		i_sfr.rd && i_sfr.addr == ADDR_ENABLE;
	endsequence

	sequence s_read_half;
		i_sfr.rd && i_sfr.addr == ADDR_HALF;
	endsequence

	a_enable_read_back: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		s_read_enable |=> o_sfr_rdata == {1'b0, $past(st_r.enable)})
		else $error("enable register read back wrong");

	a_half_read_back: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		s_read_half |=> o_sfr_rdata == {1'b0, $past(st_r.half)})
		else $error("half flags read back wrong");

	a_enable_write: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		s_write_enable |=> o_chan_enable == $past(i_sfr.wdata[6:0]))
		else $error("enable register did not take the written value");

	a_top_bit_zero: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		o_sfr_rdata[TOP_BIT] == 1'b0)
		else $error("unused top bit read as one");

	a_full_read_back: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		s_read_full |=> o_sfr_rdata == {1'b0, $past(st_r.full)})
		else $error("full flags read back wrong");

	a_irq_any: assert property (
		@(posedge i_mclk) disable iff (!i_rst_b)
		o_irq == |(o_full_irq | o_half_irq))
		else $error("combined request disagrees with channel requests");

	// Per-channel checks
	for (genvar c = 0; c < CHANNELS; c++) begin : g_chk
		a_full_sets: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			full_hit[c] |=> st_r.full[c] ##1 st_r.full[c] || $past(wr_full))
			else $error("full flag missed its terminal offset");

		a_half_sets: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			i_byte_moved[c] && {1'b0, i_offset[c]} ==
			(({1'b0, i_size[c]} + 1'b1) >> 1) |=> st_r.half[c])
			else $error("half flag missed its mid-point offset");

		a_full_sticky: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			$fell(st_r.full[c]) |-> $past(wr_full))
			else $error("full flag cleared without a software write");

		a_half_sticky: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			$fell(st_r.half[c]) |-> $past(wr_half))
			else $error("half flag cleared without a software write");

		a_full_clear: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			wr_full && !i_sfr.wdata[c] && !full_hit[c]
			|=> !st_r.full[c])
			else $error("full flag ignored a software clear");

		a_half_clear: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			wr_half && !i_sfr.wdata[c] && !half_hit[c]
			|=> !st_r.half[c])
			else $error("half flag ignored a software clear");

		a_full_irq_on: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			st_r.full[c] && i_ie.full_ie[c] |-> o_full_irq[c])
			else $error("full request missing while enabled");

		a_half_irq_off: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			o_half_irq[c] |-> st_r.half[c] && i_ie.half_ie[c])
			else $error("half request raised while not enabled");

		a_full_irq_gate: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			o_full_irq[c] |-> st_r.full[c] && i_ie.full_ie[c])
			else $error("full request raised while not enabled");

		a_half_irq_gate: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			st_r.half[c] && i_ie.half_ie[c] |-> o_half_irq[c])
			else $error("half request missing while enabled");

		a_go_needs_clear: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			full_hit[c] ##1 !wr_full |=> !o_chan_go[c])
			else $error("channel kept going with a pending flag");

		a_go_needs_enable: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			o_chan_go[c] |-> o_chan_enable[c])
			else $error("channel allowed to run while disabled");

		a_go_when_free: assert property (
			@(posedge i_mclk) disable iff (!i_rst_b)
			o_chan_enable[c] && !st_r.full[c] && !st_r.half[c]
			|-> o_chan_go[c])
			else $error("enabled channel with no flag held off");
	end

endmodule // dma_chan_flags

// *** logic/dma_unit_pkg.sv ***
// Purpose: Shared constants and carriers for the dma_unit enable/flag block
// Assumes: 8-bit special-function-register bus on the system clock
// Notes:   Offsets are byte addresses in the special-function space
package dma_unit_pkg;

	// Channel count, register width and default offset width
	localparam int          CHANNELS   = 7;
	localparam int          SFR_W      = 8;
	localparam int          TOP_BIT    = 7;
	localparam int          OFS_W_DEF  = 10;

	// Register offsets
	localparam logic [7:0]  ADDR_ENABLE = 8'hD2;
	localparam logic [7:0]  ADDR_FULL   = 8'hD3;
	localparam logic [7:0]  ADDR_HALF   = 8'hD4;

	// Reset values
	localparam logic [6:0]  RST_ENABLE  = 7'h00;
	localparam logic [6:0]  RST_FLAGS   = 7'h00;
	localparam logic [7:0]  RST_RDATA   = 8'h00;

	// One register-bus request from the core
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sfr_req_s;

	// Per-channel interrupt-enable bits of the channel configuration
	typedef struct packed {
		logic [6:0] full_ie;
		logic [6:0] half_ie;
	} chan_ie_s;

	// Whole state of the block
	typedef struct packed {
		logic [6:0] enable;
		logic [6:0] full;
		logic [6:0] half;
		logic [7:0] rdata;
	} flag_state_s;

endpackage

// *** sim/dma_chan_flags_test.sv ***
// Purpose: Register and flag scenarios for dma_chan_flags
// Assumes: Bench drives inputs on the falling edge
// Notes:   All channels share one transfer length, odd first, even after reset
`timescale 1ns/1ps
module dma_chan_flags_test
	import dma_unit_pkg::*;
;
	logic [9:0]               len = 10'h005;
	logic                     i_mclk = 1'b0;
	logic                     i_rst_b = 1'b0;
	sfr_req_s                 sfr = '0;
	chan_ie_s                 ie = '{full_ie: 7'h0F, half_ie: 7'h70};
	logic [SFR_W-1:0]         rdata, rd_v;
	logic [CHANNELS-1:0]      moved, en, go, full_irq, half_irq;
	logic [CHANNELS-1:0][9:0] offset;
	logic                     irq;
	int                       err_count = 0;
	int                       checks_done = 0;
	// 40 MHz clock
	always #12.5 i_mclk = ~i_mclk;
	// Block and engine
	dma_chan_flags dma_chan_flags_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_sfr(sfr), .o_sfr_rdata(rdata), .i_byte_moved(moved),
		.i_offset(offset), .i_size({CHANNELS{len}}), .i_ie(ie),
		.o_chan_enable(en), .o_chan_go(go), .o_full_irq(full_irq),
		.o_half_irq(half_irq), .o_irq(irq));
	dma_engine_model dma_engine_model_inst (.i_mclk(i_mclk),
		.i_rst_b(i_rst_b), .i_go(go), .i_len(len), .o_byte_moved(moved),
		.o_offset(offset));
	// Compare, access and wait helpers
	task automatic check(input string what, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic sfr_wr(input logic [7:0] a, d);
		@(negedge i_mclk) sfr = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge i_mclk) sfr.wr = 1'b0;
	endtask
	task automatic sfr_rd(input logic [7:0] a);
		@(negedge i_mclk) sfr = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge i_mclk) sfr.rd = 1'b0;
		@(negedge i_mclk) rd_v = rdata;
	endtask
	// Channel configuration through the selector; code 111 selects nothing
	task automatic set_cfg(input logic [2:0] sel, input logic [7:0] cfg);
		if (sel != 3'h7) begin
			ie.full_ie[sel] = cfg[7];
			ie.half_ie[sel] = cfg[6];
		end
	endtask
	task automatic finish_test();
		$display("Checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_irq(input logic full);
		for (int n = 0; n < 50; n++) begin
			@(negedge i_mclk);
			if ((full ? full_irq : half_irq) !== 7'h00)
				return;
		end
		err_count++;
		finish_test();
	endtask
	// Main sequence
	initial begin
		repeat (4) @(negedge i_mclk);
		i_rst_b = 1'b1;
		for (int a = 'hD2; a < 'hD6; a++) begin
			sfr_rd(8'(a));
			check("reset read", rd_v, 8'h00);
		end
		sfr_wr(ADDR_ENABLE, 8'hD5);
		sfr_rd(ADDR_ENABLE);
		check("enable", rd_v, 8'h55);
		check("enable pins", {1'b0, en}, 8'h55);
		wait_irq(1'b0);
		check("half irq", {1'b0, half_irq}, 8'h50);
		check("go held", {1'b0, go}, 8'h00);
		ie = '0;
		@(negedge i_mclk) check("gated irq", {7'h00, irq}, 8'h00);
		ie = '{full_ie: 7'h0F, half_ie: 7'h70};
		repeat (6) @(negedge i_mclk);
		sfr_rd(ADDR_HALF);
		check("half flags", rd_v, 8'h55);
		// Counter has stepped past the mid-point byte and then held
		check("half offset", offset[0][7:0], 8'h04);
		sfr_wr(ADDR_HALF, 8'h00);
		wait_irq(1'b1);
		check("full irq", {1'b0, full_irq}, 8'h05);
		check("irq line", {7'h00, irq}, 8'h01);
		sfr_rd(ADDR_FULL);
		check("full flags", rd_v, 8'h55);
		sfr_rd(ADDR_HALF);
		check("half cleared", rd_v, 8'h00);
		check("end offset", offset[0][7:0], 8'h05);
		check("idle offset", offset[1][7:0], 8'h00);
		sfr_wr(ADDR_FULL, 8'hFF);
		sfr_rd(ADDR_FULL);
		check("full top bit", rd_v, 8'h7F);
		sfr_wr(ADDR_FULL, 8'h00);
		sfr_rd(ADDR_FULL);
		check("full cleared", rd_v, 8'h00);
		check("irq idle", {7'h00, irq}, 8'h00);
		// Software-set flags, then a system reset clears all state
		sfr_wr(ADDR_FULL, 8'hFF);
		@(negedge i_mclk) i_rst_b = 1'b0;
		len = 10'h004;
		@(negedge i_mclk) i_rst_b = 1'b1;
		sfr_rd(ADDR_FULL);
		check("reset flags", rd_v, 8'h00);
		check("reset enable", {1'b0, en}, 8'h00);
		// Even length on channel 0 with both requests enabled
		set_cfg(3'h0, 8'hC0);
		sfr_wr(ADDR_ENABLE, 8'h01);
		wait_irq(1'b0);
		check("even half irq", {1'b0, half_irq}, 8'h01);
		sfr_rd(ADDR_HALF);
		check("even half flags", rd_v, 8'h01);
		check("even half offset", offset[0][7:0], 8'h03);
		sfr_wr(ADDR_HALF, 8'h00);
		wait_irq(1'b1);
		check("even full irq", {1'b0, full_irq}, 8'h01);
		sfr_rd(ADDR_FULL);
		check("even full flags", rd_v, 8'h01);
		check("even end offset", offset[0][7:0], 8'h04);
		finish_test();
	end
endmodule // dma_chan_flags_test

// *** sim/dma_engine_model.sv ***
// Purpose: Byte engine that strobes enabled channels of dma_chan_flags
// Assumes: Strobes change on the falling edge, one byte per cycle
// Notes:   Offsets restart only on reset
`timescale 1ns/1ps
module dma_engine_model
	import dma_unit_pkg::*;
(
	// Clock, reset and channel permission
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst_b,
	input  wire logic [CHANNELS-1:0]      i_go,
	input  wire logic [9:0]               i_len,
	// Engine strobes and offsets
	output logic      [CHANNELS-1:0]      o_byte_moved,
	output logic      [CHANNELS-1:0][9:0] o_offset
);
	// Advance after each moved byte, stop at the end or while held off
	always @(negedge i_mclk or negedge i_rst_b) begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (!i_rst_b) begin
				o_offset[c] = 10'h000;
				o_byte_moved[c] = 1'b0;
			end else begin
				if (o_byte_moved[c])
					o_offset[c] = o_offset[c] + 10'h001;
				o_byte_moved[c] = i_go[c] && (o_offset[c] < i_len);
			end
		end
	end
endmodule // dma_engine_model
